// file: hdl/freq_loop_ratio_params.svh
/*
   Offsets, field positions, reset values and register constants of the
   frequency-locked loop ratio register block.
   Assumes it is included by its bare name before any user of the macros.
*/
// Operation
// - multiplier, numerator and denominator fields are plain unsigned integers, LSB one
// - while enabled, new multiplier and numerator wait for an update strobe
// - while disabled, multiplier and numerator writes take effect at once
// - update strobe is bit 15 of second control register, reads zero
// - update strobe does nothing while the loop is disabled
// - loop enable is bit 0 of first control register, resets zero
// - integer multiplier is bits 9..0 of second control register, reset 8
// - fraction numerator fills third control register, reset 0x18
// - fraction denominator fills fourth control register, reset 0x7d
// - sync ratio codes 0..4 select divide by 1, 2, 4, 8, 16
// - sync path keeps its own multiplier, numerator and denominator fields
// - nonzero numerator means fractional mode; software derives values by gcd
`ifndef FREQ_LOOP_RATIO_PARAMS_SVH
`define FREQ_LOOP_RATIO_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_LOOP_ENABLE_CTRL 16'h0171
`define OFS_INTEGER_MULT_UPDATE 16'h0172
`define OFS_FRACTION_NUMERATOR 16'h0173
`define OFS_FRACTION_DENOMINATOR 16'h0174
`define OFS_SYNC_RATIO_CTRL 16'h0180
`define OFS_SYNC_INTEGER_MULT 16'h0181
`define OFS_SYNC_FRACTION_NUM 16'h0182
`define OFS_SYNC_FRACTION_DEN 16'h0183
`define OFS_LOOP_CONFIG 16'h0184
`define OFS_LOOP_STATUS 16'h0185

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define BIT_LOOP_ENABLE 0
`define BIT_UPDATE_STROBE 15
`define INT_MULT_WIDTH 10
`define FRACTION_WIDTH 16
`define SYNC_RATIO_LSB 0
`define SYNC_GAIN_LSB 3
`define BIT_SYNC_BANDWIDTH 7
`define BIT_DENOM_STAGED 0
`define BIT_STAT_PENDING 0
`define BIT_STAT_FRACTIONAL 1
`define BIT_STAT_SYNC_FRACTIONAL 2
`define RATIO_CODE_TOP 3'h4
`define RATIO_FACTOR_TOP 5'h10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_INTEGER_MULT 10'h008
`define RST_FRACTION_NUM 16'h0018
`define RST_FRACTION_DEN 16'h007d
`define RST_SYNC_RATIO 3'h0
`define RST_SYNC_GAIN 4'h0
`define RST_SYNC_BANDWIDTH 1'h0
`define RST_SYNC_INT_MULT 10'h008
`define RST_SYNC_FRACTION_NUM 16'h0000
`define RST_SYNC_FRACTION_DEN 16'h0001
`define RST_DENOM_STAGED 1'h0

`endif

// file: hdl/freq_loop_pkg.sv
/*
   Types and the ratio decode function of the loop ratio register block.
   Assumes the params header is reachable on the include path.
*/
`include "freq_loop_ratio_params.svh"

package freq_loop_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [15:0] reg_addr_t;
   typedef logic [2:0] ratio_code_t;
   typedef logic [4:0] ratio_factor_t;

   // codes above the top one saturate at the largest ratio
   function automatic ratio_factor_t ratio_factor(input ratio_code_t code);
      ratio_factor = (code >= `RATIO_CODE_TOP) ? `RATIO_FACTOR_TOP : (5'h01 << code);
   endfunction : ratio_factor
endpackage : freq_loop_pkg

// file: hdl/staged_field.sv
/*
   One loop setting with a shadow copy and an active copy.
   Assumes an active-low reset already released in step with the clock,
   and a one-cycle apply pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module staged_field #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic sys_clk,
   input wire logic rstN,
   input wire logic writeEn,
   input wire logic [WIDTH-1:0] writeData,
   input wire logic staging,
   input wire logic apply,
   output logic [WIDTH-1:0] shadowValue,
   output logic [WIDTH-1:0] activeValue,
   output logic pending
);
   logic [WIDTH-1:0] shadow_reg;
   logic [WIDTH-1:0] active_reg;
   logic [WIDTH-1:0] active_next;
   logic pending_reg;
   logic pending_next;

   // a direct write wins over an apply landing in the same cycle
   assign active_next = (writeEn && !staging) ? writeData :
                        (apply ? shadow_reg : active_reg);
   // a staged write in the apply cycle keeps the flag set
   assign pending_next = (writeEn && staging) ? 1'b1 :
                         ((apply || writeEn) ? 1'b0 : pending_reg);

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         shadow_reg <= RESET_VALUE;
         active_reg <= RESET_VALUE;
         pending_reg <= 1'b0;
      end else begin
         shadow_reg <= writeEn ? writeData : shadow_reg;
         active_reg <= active_next;
         pending_reg <= pending_next;
      end
   end

   assign shadowValue = shadow_reg;
   assign activeValue = active_reg;
   assign pending = pending_reg;
endmodule : staged_field

`default_nettype wire

// file: hdl/ratio_decode.sv
/*
   Registered decode of a ratio code into its division factor.
   Assumes an active-low reset already released in step with the clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "freq_loop_ratio_params.svh"

module ratio_decode
   import freq_loop_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstN,
   input wire freq_loop_pkg::ratio_code_t code,
   output freq_loop_pkg::ratio_factor_t factor
);
   ratio_factor_t factor_reg;

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         factor_reg <= 5'h01;
      end else begin
         factor_reg <= ratio_factor(code);
      end
   end

   assign factor = factor_reg;

   property p_ratioDecode;
      @(posedge sys_clk) disable iff (!rstN)
      (code < `RATIO_CODE_TOP) |=> (factor == (5'h01 << $past(code)));
   endproperty
   a_ratioDecode: assert property (p_ratioDecode)
      else $error("ratio factor does not match code");
endmodule : ratio_decode

`default_nettype wire

// file: hdl/freq_loop_ratio_regs.sv
/*
   Register block for the loop multiplier settings of the main and the
   synchroniser path, with staged update of multiplier and numerator.
   Assumes a register master that issues one-cycle strobes, never both at
   once, and reads data one cycle after a read strobe.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "freq_loop_ratio_params.svh"

module freq_loop_ratio_regs
   import freq_loop_pkg::*;
#(
   parameter int INT_MULT_WIDTH = `INT_MULT_WIDTH,
   parameter int FRACTION_WIDTH = `FRACTION_WIDTH
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire freq_loop_pkg::reg_addr_t regAddr,
   input wire freq_loop_pkg::reg_word_t regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output freq_loop_pkg::reg_word_t regRdData,
   output logic loopEnable,
   output logic [INT_MULT_WIDTH-1:0] integerMultiplier,
   output logic [FRACTION_WIDTH-1:0] fractionNumerator,
   output logic [FRACTION_WIDTH-1:0] fractionDenominator,
   output logic fractionalMode,
   output freq_loop_pkg::ratio_code_t syncRatioDivider,
   output freq_loop_pkg::ratio_factor_t syncDivideFactor,
   output logic [3:0] syncLoopGain,
   output logic syncBandwidthSelect,
   output logic [INT_MULT_WIDTH-1:0] syncIntegerMultiplier,
   output logic [FRACTION_WIDTH-1:0] syncFractionNumerator,
   output logic [FRACTION_WIDTH-1:0] syncFractionDenominator,
   output logic syncFractionalMode
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rstMeta_reg;
   logic rstSync_reg;
   logic rstN;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   assign rstN = rstSync_reg;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic wrCtrl1;
   logic wrCtrl2;
   logic wrNum;
   logic wrDen;
   logic wrSyncCtrl;
   logic wrSyncN;
   logic wrSyncNum;
   logic wrSyncDen;
   logic wrConfig;
   logic strobeWrite;

   assign wrCtrl1 = regWr && (regAddr == `OFS_LOOP_ENABLE_CTRL);
   assign wrCtrl2 = regWr && (regAddr == `OFS_INTEGER_MULT_UPDATE);
   assign wrNum = regWr && (regAddr == `OFS_FRACTION_NUMERATOR);
   assign wrDen = regWr && (regAddr == `OFS_FRACTION_DENOMINATOR);
   assign wrSyncCtrl = regWr && (regAddr == `OFS_SYNC_RATIO_CTRL);
   assign wrSyncN = regWr && (regAddr == `OFS_SYNC_INTEGER_MULT);
   assign wrSyncNum = regWr && (regAddr == `OFS_SYNC_FRACTION_NUM);
   assign wrSyncDen = regWr && (regAddr == `OFS_SYNC_FRACTION_DEN);
   assign wrConfig = regWr && (regAddr == `OFS_LOOP_CONFIG);
   assign strobeWrite = wrCtrl2 && regWrData[`BIT_UPDATE_STROBE];

   // ----------------------------------------------------------------
   // control flops
   // ----------------------------------------------------------------
   logic loopEnable_reg;
   logic applyPulse_reg;
   logic denomStaged_reg;
   logic fractionalMode_reg;
   logic syncFractionalMode_reg;
   ratio_code_t syncRatio_reg;
   logic [3:0] syncGain_reg;
   logic syncBandwidth_reg;
   logic [INT_MULT_WIDTH-1:0] syncN_reg;
   logic [FRACTION_WIDTH-1:0] syncNum_reg;
   logic [FRACTION_WIDTH-1:0] syncDen_reg;

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         loopEnable_reg <= 1'b0;
         applyPulse_reg <= 1'b0;
         denomStaged_reg <= `RST_DENOM_STAGED;
      end else begin
         loopEnable_reg <= wrCtrl1 ? regWrData[`BIT_LOOP_ENABLE] : loopEnable_reg;
         // the strobe itself is never stored, so it reads back as zero
         applyPulse_reg <= strobeWrite && loopEnable_reg;
         denomStaged_reg <= wrConfig ? regWrData[`BIT_DENOM_STAGED] : denomStaged_reg;
      end
   end

   // sync fields are taken straight; nothing in the sync path is staged
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         syncRatio_reg <= `RST_SYNC_RATIO;
         syncGain_reg <= `RST_SYNC_GAIN;
         syncBandwidth_reg <= `RST_SYNC_BANDWIDTH;
         syncN_reg <= `RST_SYNC_INT_MULT;
         syncNum_reg <= `RST_SYNC_FRACTION_NUM;
         syncDen_reg <= `RST_SYNC_FRACTION_DEN;
      end else begin
         if (wrSyncCtrl) begin
            syncRatio_reg <= regWrData[`SYNC_RATIO_LSB +: 3];
            syncGain_reg <= regWrData[`SYNC_GAIN_LSB +: 4];
            syncBandwidth_reg <= regWrData[`BIT_SYNC_BANDWIDTH];
         end
         syncN_reg <= wrSyncN ? regWrData[INT_MULT_WIDTH-1:0] : syncN_reg;
         syncNum_reg <= wrSyncNum ? regWrData[FRACTION_WIDTH-1:0] : syncNum_reg;
         syncDen_reg <= wrSyncDen ? regWrData[FRACTION_WIDTH-1:0] : syncDen_reg;
      end
   end

   // ----------------------------------------------------------------
   // staged main path fields
   // ----------------------------------------------------------------
   logic [INT_MULT_WIDTH-1:0] nShadow;
   logic [INT_MULT_WIDTH-1:0] nActive;
   logic [FRACTION_WIDTH-1:0] numShadow;
   logic [FRACTION_WIDTH-1:0] numActive;
   logic [FRACTION_WIDTH-1:0] denShadow;
   logic [FRACTION_WIDTH-1:0] denActive;
   logic nPending;
   logic numPending;
   logic denPending;
   logic denStaging;

   // staging the denominator is optional; off, it drives the loop at once
   assign denStaging = loopEnable_reg && denomStaged_reg;

   staged_field #(
      .WIDTH(INT_MULT_WIDTH),
      .RESET_VALUE(`RST_INTEGER_MULT)
   ) u_intMult (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .writeEn(wrCtrl2),
      .writeData(regWrData[INT_MULT_WIDTH-1:0]),
      .staging(loopEnable_reg),
      .apply(applyPulse_reg),
      .shadowValue(nShadow),
      .activeValue(nActive),
      .pending(nPending)
   );

   staged_field #(
      .WIDTH(FRACTION_WIDTH),
      .RESET_VALUE(`RST_FRACTION_NUM)
   ) u_numerator (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .writeEn(wrNum),
      .writeData(regWrData[FRACTION_WIDTH-1:0]),
      .staging(loopEnable_reg),
      .apply(applyPulse_reg),
      .shadowValue(numShadow),
      .activeValue(numActive),
      .pending(numPending)
   );

   staged_field #(
      .WIDTH(FRACTION_WIDTH),
      .RESET_VALUE(`RST_FRACTION_DEN)
   ) u_denominator (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .writeEn(wrDen),
      .writeData(regWrData[FRACTION_WIDTH-1:0]),
      .staging(denStaging),
      .apply(applyPulse_reg),
      .shadowValue(denShadow),
      .activeValue(denActive),
      .pending(denPending)
   );

   ratio_decode u_syncRatio (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .code(syncRatio_reg),
      .factor(syncDivideFactor)
   );

   // mode flags lag the active values by one cycle; the core only samples them
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         fractionalMode_reg <= 1'b1;
         syncFractionalMode_reg <= 1'b0;
      end else begin
         fractionalMode_reg <= (numActive != '0);
         syncFractionalMode_reg <= (syncNum_reg != '0);
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   reg_word_t readValue;
   reg_word_t statusWord;
   reg_word_t syncCtrlWord;
   reg_word_t rdData_reg;

   assign statusWord = {13'h0000, syncFractionalMode_reg, fractionalMode_reg,
                        nPending || numPending || denPending};
   assign syncCtrlWord = {8'h00, syncBandwidth_reg, syncGain_reg, syncRatio_reg};
   // fields are unsigned integers, so reads return the bits unchanged
   assign readValue =
      (regAddr == `OFS_LOOP_ENABLE_CTRL) ? {15'h0000, loopEnable_reg} :
      (regAddr == `OFS_INTEGER_MULT_UPDATE) ?
         reg_word_t'(nShadow) :
      (regAddr == `OFS_FRACTION_NUMERATOR) ? reg_word_t'(numShadow) :
      (regAddr == `OFS_FRACTION_DENOMINATOR) ? reg_word_t'(denShadow) :
      (regAddr == `OFS_SYNC_RATIO_CTRL) ? syncCtrlWord :
      (regAddr == `OFS_SYNC_INTEGER_MULT) ? reg_word_t'(syncN_reg) :
      (regAddr == `OFS_SYNC_FRACTION_NUM) ? reg_word_t'(syncNum_reg) :
      (regAddr == `OFS_SYNC_FRACTION_DEN) ? reg_word_t'(syncDen_reg) :
      (regAddr == `OFS_LOOP_CONFIG) ? {15'h0000, denomStaged_reg} :
      (regAddr == `OFS_LOOP_STATUS) ? statusWord :
      16'h0000;

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         rdData_reg <= 16'h0000;
      end else begin
         rdData_reg <= regRd ? readValue : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign regRdData = rdData_reg;
   assign loopEnable = loopEnable_reg;
   assign integerMultiplier = nActive;
   assign fractionNumerator = numActive;
   assign fractionDenominator = denActive;
   assign fractionalMode = fractionalMode_reg;
   assign syncRatioDivider = syncRatio_reg;
   assign syncLoopGain = syncGain_reg;
   assign syncBandwidthSelect = syncBandwidth_reg;
   assign syncIntegerMultiplier = syncN_reg;
   assign syncFractionNumerator = syncNum_reg;
   assign syncFractionDenominator = syncDen_reg;
   assign syncFractionalMode = syncFractionalMode_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_strobeWhileEnabled;
      strobeWrite && loopEnable_reg;
   endsequence

   sequence s_applyThenHold;
      applyPulse_reg ##1 (integerMultiplier == $past(regWrData[INT_MULT_WIDTH-1:0], 2));
   endsequence

   property p_stagedHold;
      @(posedge sys_clk) disable iff (!rstN)
      (wrCtrl2 && loopEnable_reg && !strobeWrite && !applyPulse_reg) |=> $stable(integerMultiplier);
   endproperty
   a_stagedHold: assert property (p_stagedHold)
      else $error("multiplier changed without an update strobe");

   property p_directWrite;
      @(posedge sys_clk) disable iff (!rstN)
      (wrNum && !loopEnable_reg) |=> (fractionNumerator == $past(regWrData));
   endproperty
   a_directWrite: assert property (p_directWrite)
      else $error("numerator write while disabled not taken at once");

   property p_strobeApplies;
      @(posedge sys_clk) disable iff (!rstN)
      s_strobeWhileEnabled |=> s_applyThenHold;
   endproperty
   a_strobeApplies: assert property (p_strobeApplies)
      else $error("update strobe did not apply the written multiplier");

   property p_strobeDisabled;
      @(posedge sys_clk) disable iff (!rstN)
      (strobeWrite && !loopEnable_reg) |=> !applyPulse_reg;
   endproperty
   a_strobeDisabled: assert property (p_strobeDisabled)
      else $error("apply pulse while the loop is disabled");

   property p_strobeReadsZero;
      @(posedge sys_clk) disable iff (!rstN)
      (regRd && (regAddr == `OFS_INTEGER_MULT_UPDATE)) |=> !regRdData[`BIT_UPDATE_STROBE];
   endproperty
   a_strobeReadsZero: assert property (p_strobeReadsZero)
      else $error("update strobe read back as one");

   property p_enableFollows;
      @(posedge sys_clk) disable iff (!rstN)
      wrCtrl1 |=> (loopEnable == $past(regWrData[`BIT_LOOP_ENABLE]));
   endproperty
   a_enableFollows: assert property (p_enableFollows)
      else $error("loop enable did not follow its write");

   property p_denomDirect;
      @(posedge sys_clk) disable iff (!rstN)
      (wrDen && !denomStaged_reg) |=> (fractionDenominator == $past(regWrData));
   endproperty
   a_denomDirect: assert property (p_denomDirect)
      else $error("unstaged denominator write not taken at once");

   property p_fractionalFlag;
      @(posedge sys_clk) disable iff (!rstN)
      1'b1 |=> (fractionalMode == ($past(fractionNumerator) != '0));
   endproperty
   a_fractionalFlag: assert property (p_fractionalFlag)
      else $error("fractional mode flag does not match numerator");

   property p_syncSeparate;
      @(posedge sys_clk) disable iff (!rstN)
      (wrCtrl2 && !wrSyncN) |=> $stable(syncIntegerMultiplier);
   endproperty
   a_syncSeparate: assert property (p_syncSeparate)
      else $error("main multiplier write disturbed the sync multiplier");
endmodule : freq_loop_ratio_regs

`default_nettype wire

// file: test/tb_top.sv
/*
   Self-checking bench of the loop ratio register block: reset values,
   direct and staged multiplier updates, denominator staging, sync path.
   Assumes the design package and the params header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "freq_loop_ratio_params.svh"

module tb_top;
   import freq_loop_pkg::*;
   logic sys_clk, nrst, regWr, regRd;
   reg_addr_t regAddr;
   reg_word_t regWrData, regRdData;
   logic loopEnable, fractionalMode, syncBandwidthSelect, syncFractionalMode;
   logic [9:0] integerMultiplier, syncIntegerMultiplier, nA, nB;
   logic [15:0] fractionNumerator, fractionDenominator, thA, dA, dB;
   logic [15:0] syncFractionNumerator, syncFractionDenominator;
   ratio_code_t syncRatioDivider;
   ratio_factor_t syncDivideFactor;
   logic [3:0] syncLoopGain;
   logic [31:0] lfsrState;
   int mismatches = 0;
   int checked = 0;

   freq_loop_ratio_regs u_freq_loop_ratio_regs (
      .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .loopEnable(loopEnable),
      .integerMultiplier(integerMultiplier), .fractionNumerator(fractionNumerator),
      .fractionDenominator(fractionDenominator), .fractionalMode(fractionalMode),
      .syncRatioDivider(syncRatioDivider), .syncDivideFactor(syncDivideFactor),
      .syncLoopGain(syncLoopGain), .syncBandwidthSelect(syncBandwidthSelect),
      .syncIntegerMultiplier(syncIntegerMultiplier),
      .syncFractionNumerator(syncFractionNumerator),
      .syncFractionDenominator(syncFractionDenominator),
      .syncFractionalMode(syncFractionalMode)
   );

   // ----------------------------------------------------------------
   // clock, helpers
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      lfsrNext = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction : lfsrNext

   // codes beyond the top one all mean the largest ratio
   function automatic logic [15:0] expFactor(input logic [2:0] c);
      expFactor = (c > 3'h3) ? 16'h0010 : (16'h0001 << c);
   endfunction : expFactor

   function automatic int gcd(input int a, input int b);
      int t;
      while (b != 0) begin
         t = a % b;
         a = b;
         b = t;
      end
      gcd = a;
   endfunction : gcd

   // software side: reference 1 to 13.5 MHz at ratio one, frequencies in kHz
   task automatic pickRatio(input logic [31:0] r, output logic [9:0] n,
                            output logic [15:0] num, output logic [15:0] den);
      int fRef;
      int fOsc;
      int g;
      fRef = 1000 + (r[15:0] % 12500);
      fOsc = 90000 + (r[31:16] % 14001);
      g = gcd(fRef, fOsc);
      n = 10'(fOsc / fRef);
      num = 16'((fOsc % fRef) / g);
      den = 16'(fRef / g);
   endtask : pickRatio

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input reg_addr_t a, input reg_word_t d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input reg_addr_t a, input reg_word_t exp);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData, exp);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic summarize;
      $display("counts: checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (100000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = '0;
      regWrData = '0;
      nrst = 1'b0;
      lfsrState = 32'hc09087dd;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      cyc(3);
      chk({15'h0, loopEnable}, 16'h0000);
      chk({6'h0, integerMultiplier}, 16'h0008);
      chk(fractionNumerator, 16'h0018);
      chk(fractionDenominator, 16'h007d);
      chk({6'h0, syncIntegerMultiplier}, 16'h0008);
      chk({11'h0, syncDivideFactor}, 16'h0001);
      rd(`OFS_LOOP_ENABLE_CTRL, 16'h0000);
      rd(`OFS_INTEGER_MULT_UPDATE, 16'h0008);
      rd(`OFS_FRACTION_NUMERATOR, 16'h0018);
      rd(`OFS_FRACTION_DENOMINATOR, 16'h007d);
      cyc(1);
      chk(regRdData, 16'h0000);
      $display("test reset done");

      lfsrState = lfsrNext(lfsrState);
      nB = lfsrState[9:0];
      wr(`OFS_INTEGER_MULT_UPDATE, {6'h0, nB});
      cyc(1);
      chk({6'h0, integerMultiplier}, {6'h0, nB});
      wr(`OFS_FRACTION_NUMERATOR, 16'h0000);
      cyc(2);
      chk({15'h0, fractionalMode}, 16'h0000);
      wr(`OFS_FRACTION_NUMERATOR, 16'h0003);
      cyc(2);
      chk(fractionNumerator, 16'h0003);
      chk({15'h0, fractionalMode}, 16'h0001);
      nB = ~nB;
      wr(`OFS_INTEGER_MULT_UPDATE, {6'h20, nB});
      cyc(3);
      chk({6'h0, integerMultiplier}, {6'h0, nB});
      rd(`OFS_LOOP_STATUS, 16'h0002);
      $display("test direct done");

      wr(`OFS_LOOP_ENABLE_CTRL, 16'h0001);
      cyc(1);
      chk({15'h0, loopEnable}, 16'h0001);
      lfsrState = lfsrNext(lfsrState);
      pickRatio(lfsrState, nA, thA, dA);
      wr(`OFS_INTEGER_MULT_UPDATE, {6'h0, nA});
      wr(`OFS_FRACTION_NUMERATOR, thA);
      cyc(3);
      chk({6'h0, integerMultiplier}, {6'h0, nB});
      chk(fractionNumerator, 16'h0003);
      rd(`OFS_INTEGER_MULT_UPDATE, {6'h0, nA});
      rd(`OFS_LOOP_STATUS, 16'h0003);
      wr(`OFS_FRACTION_DENOMINATOR, dA);
      cyc(2);
      chk(fractionDenominator, dA);
      wr(`OFS_INTEGER_MULT_UPDATE, {6'h20, nA});
      cyc(2);
      chk({6'h0, integerMultiplier}, {6'h0, nA});
      chk(fractionNumerator, thA);
      rd(`OFS_INTEGER_MULT_UPDATE, {6'h0, nA});
      rd(`OFS_LOOP_STATUS, {14'h0, thA != 16'h0, 1'b0});
      $display("test staged done");

      // adding the numerator keeps the pair co-prime and the fraction below one
      dB = dA + ((thA == 16'h0) ? 16'h0001 : thA);
      wr(`OFS_LOOP_CONFIG, 16'h0001);
      wr(`OFS_FRACTION_DENOMINATOR, dB);
      cyc(2);
      chk(fractionDenominator, dA);
      wr(`OFS_INTEGER_MULT_UPDATE, {6'h20, nA});
      cyc(3);
      chk(fractionDenominator, dB);
      $display("test denominator done");

      for (int c = 0; c < 8; c++) begin
         lfsrState = lfsrNext(lfsrState);
         wr(`OFS_SYNC_RATIO_CTRL, {8'h0, lfsrState[7:3], c[2:0]});
         cyc(2);
         chk({13'h0, syncRatioDivider}, {13'h0, c[2:0]});
         chk({11'h0, syncDivideFactor}, expFactor(c[2:0]));
         chk({12'h0, syncLoopGain}, {12'h0, lfsrState[6:3]});
         chk({15'h0, syncBandwidthSelect}, {15'h0, lfsrState[7]});
      end
      // sync reference 1 to 13.5 MHz: divide by 1, gain code 4, wide bandwidth
      wr(`OFS_SYNC_RATIO_CTRL, 16'h0020);
      lfsrState = lfsrNext(lfsrState);
      pickRatio(lfsrState, nB, dB, dA);
      wr(`OFS_SYNC_INTEGER_MULT, {6'h0, nB});
      wr(`OFS_SYNC_FRACTION_NUM, dB);
      wr(`OFS_SYNC_FRACTION_DEN, dA);
      cyc(2);
      chk({12'h0, syncLoopGain}, 16'h0004);
      chk({11'h0, syncDivideFactor}, 16'h0001);
      chk({6'h0, syncIntegerMultiplier}, {6'h0, nB});
      chk(syncFractionNumerator, dB);
      chk(syncFractionDenominator, dA);
      chk({15'h0, syncFractionalMode}, {15'h0, dB != 16'h0});
      chk({6'h0, integerMultiplier}, {6'h0, nA});
      $display("test sync done");

      rd(16'h0100, 16'h0000);
      wr(`OFS_LOOP_STATUS, 16'hffff);
      rd(`OFS_LOOP_STATUS, {13'h0, dB != 16'h0, thA != 16'h0, 1'b0});
      wr(`OFS_LOOP_ENABLE_CTRL, 16'h0000);
      wr(`OFS_FRACTION_NUMERATOR, 16'h0000);
      cyc(2);
      chk(fractionNumerator, 16'h0000);
      chk({15'h0, fractionalMode}, 16'h0000);
      $display("test refusal done");
      summarize();
   end
endmodule : tb_top

`default_nettype wire
